// ---- verilog/vdac_pkg.sv ----
// package for the video dac input register and level decode
// assumes one conversion clock domain; levels are in millivolts
package vdac_pkg;
  // ****************************************
  // widths
  // ****************************************
  localparam int unsigned DATA_W = 10; // data word width
  localparam int unsigned LEVEL_W = 13; // millivolt output field
  // ****************************************
  // output levels in millivolts
  // ****************************************
  localparam logic [12:0] WHITE_MV = 13'h1388; // 5000 mv, full scale
  localparam logic [12:0] BLACK_MV = 13'h0fa0; // 4000 mv, zero code
  localparam logic [12:0] BLANK_MV = 13'h0f4f; // 3919 mv
  localparam logic [12:0] SYNC_MV = 13'h0d9e; // 3486 mv, lowest level
  localparam logic [9:0] DATA_MAX = 10'h3ff; // all-ones code
  // ****************************************
  // timing
  // ****************************************
  localparam int unsigned CLK_HZ = 40000000; // system clock rate
  localparam int unsigned MAX_RATE_SPS = 25000000; // conversion ceiling
  // least clocks between words: ceil(clk / rate)
  localparam int unsigned MIN_GAP_CYC = (CLK_HZ + MAX_RATE_SPS - 1) / MAX_RATE_SPS;
  localparam logic [1:0] GAP_CYC = 2'(MIN_GAP_CYC);
  localparam logic [1:0] GAP_RST = 2'h0; // gap counter after reset
  // ****************************************
  // decode selection
  // ****************************************
  typedef enum logic [1:0] {
    VDAC_SEL_GREY = 2'b00,
    VDAC_SEL_BLANK = 2'b01,
    VDAC_SEL_SYNC = 2'b11
  } vdac_sel_t;
endpackage

// ---- verilog/vdac_level_map.sv ----
// grey-scale level mapping from a captured code
// assumes code and invert come from the input register
`timescale 1ns/10ps
`default_nettype none
module vdac_level_map (
  input wire logic [9:0] code,
  input wire logic invert,
  output logic [12:0] level_mv
);
  import vdac_pkg::*;
  // ****************************************
  // linear map
  // ****************************************
  logic [9:0] eff_code; // code after optional inversion
  logic [22:0] scaled; // code times the 1000 mv span
  // even monotonic steps, black at zero, white at all ones
  always_comb begin
    eff_code = invert ? (DATA_MAX - code) : code; // reversed grey scale
    scaled = 23'(eff_code) * 23'(WHITE_MV - BLACK_MV);
    // division rounds down; exact at both endpoints
    level_mv = BLACK_MV + 13'(scaled / 23'(DATA_MAX));
  end
endmodule
`default_nettype wire

// ---- verilog/vdac_input_reg.sv ----
// input register and level decode of a 10-bit video dac
// assumes a source synchronous to sys_clk presenting data and controls
`timescale 1ns/10ps
`default_nettype none
module vdac_input_reg (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic [vdac_pkg::DATA_W-1:0] pix_data,
  input wire logic pix_valid,
  input wire logic sync_in,
  input wire logic blank_in,
  input wire logic inverse_in,
  output logic pix_ready,
  output logic [vdac_pkg::LEVEL_W-1:0] level_mv,
  output logic [1:0] level_sel,
  output logic rate_err
);
  import vdac_pkg::*;
  // ****************************************
  // input register state
  // ****************************************
  logic [9:0] held_data; // captured pixel word
  logic held_sync; // captured sync control
  logic held_blank; // captured blank control
  logic held_inv; // captured inverse control
  logic [1:0] gap; // clocks left before next accept
  logic [9:0] next_held_data;
  logic next_held_sync;
  logic next_held_blank;
  logic next_held_inv;
  logic [1:0] next_gap;
  logic take; // word accepted this clock
  logic [12:0] grey_mv; // grey-scale level of held word
  logic [12:0] next_level_mv;
  vdac_sel_t sel; // chosen output source
  logic next_rate_err;
  // limitation: a source running faster is throttled, never queued
  // ready while the rate window allows a word
  assign pix_ready = (gap == 2'h0);
  assign take = pix_valid && pix_ready;
  // ****************************************
  // capture
  // ****************************************
  // controls ride with their pixel so effects line up
  always_comb begin
    next_held_data = held_data;
    next_held_sync = held_sync;
    next_held_blank = held_blank;
    next_held_inv = held_inv;
    next_gap = (gap != 2'h0) ? gap - 2'h1 : gap;
    next_rate_err = rate_err;
    if (take) begin
      // every bit updated together, one edge
      next_held_data = pix_data;
      next_held_sync = sync_in; // high means active
      next_held_blank = blank_in;
      next_held_inv = inverse_in;
      next_gap = GAP_CYC - 2'h1;
    end else if (pix_valid) begin
      // source ran faster than the conversion rate
      next_rate_err = 1'b1;
    end
  end
  // rising edge stands in for the falling conversion edge of the pin clock
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      held_data <= 10'h000;
      held_sync <= 1'b0;
      held_blank <= 1'b0;
      held_inv <= 1'b0;
      gap <= GAP_RST;
      rate_err <= 1'b0;
    end else begin
      held_data <= next_held_data;
      held_sync <= next_held_sync;
      held_blank <= next_held_blank;
      held_inv <= next_held_inv;
      gap <= next_gap;
      rate_err <= next_rate_err;
    end
  end
  // ****************************************
  // decode
  // ****************************************
  // only the register feeds the map, never the pins
  vdac_level_map u_map (
    .code(held_data),
    .invert(held_inv),
    .level_mv(grey_mv)
  );
  // sync over blank over data; levels keep video ratios
  always_comb begin
    if (held_sync) begin
      sel = VDAC_SEL_SYNC;
      next_level_mv = SYNC_MV;
    end else if (held_blank) begin
      sel = VDAC_SEL_BLANK;
      next_level_mv = BLANK_MV;
    end else begin
      sel = VDAC_SEL_GREY;
      next_level_mv = grey_mv;
    end
  end
  // registered level: output moves one clock after capture, glitch free
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      level_mv <= BLACK_MV;
      level_sel <= 2'h0;
    end else begin
      level_mv <= next_level_mv;
      level_sel <= sel;
    end
  end
  // ****************************************
  // checks
  // ****************************************
  // answers land two clocks after the take: capture, then output register
  AST_SYNC_LEVEL: assert property (@(posedge sys_clk) disable iff (reset)
    (take && sync_in) |=> ##1 (level_mv == SYNC_MV))
    else $error("sync did not give sync level");
  AST_BLANK_LEVEL: assert property (@(posedge sys_clk) disable iff (reset)
    (take && !sync_in && blank_in) |=> ##1 (level_mv == BLANK_MV))
    else $error("blank did not give blank level");
  AST_WHITE: assert property (@(posedge sys_clk) disable iff (reset)
    (take && !sync_in && !blank_in && !inverse_in && pix_data == DATA_MAX)
    |=> ##1 (level_mv == WHITE_MV))
    else $error("all ones not white");
  AST_BLACK: assert property (@(posedge sys_clk) disable iff (reset)
    (take && !sync_in && !blank_in && !inverse_in && pix_data == 10'h000)
    |=> ##1 (level_mv == BLACK_MV))
    else $error("all zeros not black");
  AST_INV_WHITE: assert property (@(posedge sys_clk) disable iff (reset)
    (take && !sync_in && !blank_in && inverse_in && pix_data == DATA_MAX)
    |=> ##1 (level_mv == BLACK_MV))
    else $error("inverse all ones not black");
  AST_HOLD: assert property (@(posedge sys_clk) disable iff (reset)
    (!take ##1 !take) |=> $stable(level_mv))
    else $error("output moved without a capture");
  AST_CAPTURE: assert property (@(posedge sys_clk) disable iff (reset)
    take |=> (held_data == $past(pix_data)) && (held_sync == $past(sync_in)))
    else $error("word and controls not captured together");
  AST_RATE: assert property (@(posedge sys_clk) disable iff (reset)
    take |=> !pix_ready)
    else $error("accepted faster than conversion rate");
  // inverse black end must reach white
  AST_INV_BLACK: assert property (@(posedge sys_clk) disable iff (reset)
    (take && !sync_in && !blank_in && inverse_in && pix_data == 10'h000)
    |=> ##1 (level_mv == WHITE_MV))
    else $error("inverse all zeros not white");
  // sync must win the selection even with blank set
  AST_SYNC_SEL: assert property (@(posedge sys_clk) disable iff (reset)
    (take && sync_in) |=> ##1 (level_sel == VDAC_SEL_SYNC))
    else $error("sync not selected");
  // blank must win over data and inverse
  AST_BLANK_SEL: assert property (@(posedge sys_clk) disable iff (reset)
    (take && !sync_in && blank_in) |=> ##1 (level_sel == VDAC_SEL_BLANK))
    else $error("blank not selected");
  // ****************************************
  // capture checks
  // ****************************************
  // blank and inverse belong to the same pixel as the data
  AST_CTRL_CAPTURE: assert property (@(posedge sys_clk) disable iff (reset)
    take |=> (held_blank == $past(blank_in)) && (held_inv == $past(inverse_in)))
    else $error("blank or inverse not captured with the word");
  // pins reach the held word only through a take
  AST_NO_PIN_PATH: assert property (@(posedge sys_clk) disable iff (reset)
    !take |=> $stable(held_data) && $stable(held_sync)
    && $stable(held_blank) && $stable(held_inv))
    else $error("held word changed without a take");
  // ****************************************
  // rate checks
  // ****************************************
  // an offer inside the gap must raise the sticky flag
  AST_ERR_SET: assert property (@(posedge sys_clk) disable iff (reset)
    (pix_valid && !pix_ready) |=> rate_err)
    else $error("refused offer did not flag");
  // only reset clears the flag
  AST_ERR_STICKY: assert property (@(posedge sys_clk) disable iff (reset)
    rate_err |=> rate_err)
    else $error("rate flag dropped without reset");
  // one idle clock only, so full rate is still reachable
  AST_READY_BACK: assert property (@(posedge sys_clk) disable iff (reset)
    !pix_ready |=> pix_ready)
    else $error("ready held low too long");
  // ****************************************
  // level order checks
  // ****************************************
  // plain scale: a higher code never gives a darker level
  AST_MONO: assert property (@(posedge sys_clk) disable iff (reset)
    (!held_inv && !$past(held_inv) && held_data > $past(held_data))
    |-> (grey_mv >= $past(grey_mv)))
    else $error("grey level fell as code rose");
  // reversed scale: a higher code never gives a brighter level
  AST_MONO_INV: assert property (@(posedge sys_clk) disable iff (reset)
    (held_inv && $past(held_inv) && held_data > $past(held_data))
    |-> (grey_mv <= $past(grey_mv)))
    else $error("inverse grey level rose as code rose");
  // grey output stays inside the one volt swing
  AST_GREY_SPAN: assert property (@(posedge sys_clk) disable iff (reset)
    (level_sel == VDAC_SEL_GREY) |-> (level_mv >= BLACK_MV && level_mv <= WHITE_MV))
    else $error("grey level outside black to white");
  // blank selection always carries the blank level
  AST_BLANK_BAND: assert property (@(posedge sys_clk) disable iff (reset)
    (level_sel == VDAC_SEL_BLANK) |-> (level_mv == BLANK_MV))
    else $error("blank selection with wrong level");
  // sync selection always carries the sync level
  AST_SYNC_BAND: assert property (@(posedge sys_clk) disable iff (reset)
    (level_sel == VDAC_SEL_SYNC) |-> (level_mv == SYNC_MV))
    else $error("sync selection with wrong level");
  // nothing may go below sync, the lowest level
  AST_SYNC_FLOOR: assert property (@(posedge sys_clk) disable iff (reset)
    (level_mv >= SYNC_MV))
    else $error("output below sync level");
endmodule
`default_nettype wire

// ---- bench/vdac_src_model.sv ----
// video source model feeding pixel words and controls to the dac
// assumes sys_clk rising edge; hurry makes it offer words too early
`timescale 1ns/10ps
`default_nettype none
module vdac_src_model (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic pix_ready,
  input wire logic hurry,
  output logic [9:0] pix_data,
  output logic pix_valid,
  output logic sync_in,
  output logic blank_in,
  output logic inverse_in
);
  int seed = 32'h7d666ce5; // fixed seed, repeatable runs
  logic [31:0] r; // fresh random draw each clock
  logic ld; // load a new word this edge
  initial begin
    {pix_data, pix_valid, sync_in, blank_in, inverse_in} = 14'h0000;
  end
  // ****************************************
  // offer a word, hold it until taken
  // ****************************************
  always @(posedge sys_clk) begin
    r = $random(seed);
    ld = 1'b0;
    if (reset) begin
      pix_valid <= 1'b0;
    end else if (pix_valid && pix_ready) begin
      pix_valid <= hurry; // back off at least one clock unless told to hurry
      ld = hurry;
      if (!hurry) begin
        // released lines show the inverse, never a stale copy
        {pix_data, sync_in, blank_in, inverse_in} <= ~{pix_data, sync_in, blank_in, inverse_in};
      end
    end else if (!pix_valid && r[3:0] != 4'h0) begin
      pix_valid <= 1'b1; // launched just after the edge
      ld = 1'b1;
    end
    if (ld) begin
      // endpoints favoured so both extremes appear often
      pix_data <= (r[5:4] == 2'h0) ? 10'h000 : (r[5:4] == 2'h1) ? 10'h3ff : r[15:6];
      sync_in <= (r[17:16] == 2'h0); // controls active high
      blank_in <= (r[19:18] == 2'h0);
      inverse_in <= r[20];
    end
  end
endmodule
`default_nettype wire

// ---- bench/tb_video_dac_input_register_control.sv ----
// self-checking bench for the video dac input register
// assumes the source model drives all pixel inputs
`timescale 1ns/10ps
`default_nettype none
module tb_video_dac_input_register_control;
  import vdac_pkg::*;
  `define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin miscompares++; \
    $display("Error %0t: got %h exp %h", $time, a, b); end end
  logic sys_clk = 1'b0; // 40 mhz clock
  logic reset = 1'b1; // synchronous, active high
  logic hurry = 1'b0; // source skips its back-off clock after a take when set
  logic [9:0] pix_data;
  logic pix_valid, sync_in, blank_in, inverse_in, pix_ready, rate_err;
  logic [12:0] level_mv;
  logic [1:0] level_sel;
  int miscompares = 0, cmp_count = 0, n = 0;
  int lvl_q[$], sel_q[$], due_q[$]; // expected answers in flight
  int exp_lvl, exp_sel, code; // one answer popped before comparing
  int gap_left = 0; // clocks the rules still forbid a new word
  logic exp_err = 1'b0; // sticky refusal flag the rules predict
  always #12.5 sys_clk = ~sys_clk;
  vdac_src_model i_src (.sys_clk(sys_clk), .reset(reset), .pix_ready(pix_ready),
    .hurry(hurry), .pix_data(pix_data), .pix_valid(pix_valid), .sync_in(sync_in),
    .blank_in(blank_in), .inverse_in(inverse_in));
  vdac_input_reg i_dut (.sys_clk(sys_clk), .reset(reset), .pix_data(pix_data),
    .pix_valid(pix_valid), .sync_in(sync_in), .blank_in(blank_in),
    .inverse_in(inverse_in), .pix_ready(pix_ready), .level_mv(level_mv),
    .level_sel(level_sel), .rate_err(rate_err));
  // ****************************************
  // reference model: take, then answer two edges later
  // ****************************************
  always @(posedge sys_clk) begin
    n = n + 1;
    if (reset) begin
      lvl_q.delete();
      sel_q.delete();
      due_q.delete();
      gap_left = 0;
      exp_err = 1'b0;
    end else if (pix_valid && gap_left == 0) begin
      // sync beats blank beats grey; inverse flips grey only
      code = inverse_in ? 1023 - int'(pix_data) : int'(pix_data);
      lvl_q.push_back(sync_in ? 3486 : blank_in ? 3919 : 4000 + (code * 1000) / 1023);
      sel_q.push_back(sync_in ? 3 : blank_in ? 1 : 0);
      due_q.push_back(n + 2);
      gap_left = MIN_GAP_CYC - 1; // idle clocks at 25 msps of 40 mhz
    end else begin
      if (pix_valid) exp_err = 1'b1; // offered inside the gap: refused
      if (gap_left > 0) gap_left = gap_left - 1;
    end
    #1;
    `CHK(pix_ready, gap_left == 0)
    `CHK(rate_err, exp_err)
    if (due_q.size() > 0 && due_q[0] == n) begin
      exp_lvl = lvl_q.pop_front();
      exp_sel = sel_q.pop_front();
      void'(due_q.pop_front());
      `CHK(level_mv, 13'(exp_lvl))
      `CHK(level_sel, 2'(exp_sel))
    end
  end
  task automatic end_sim;
    $display("comparisons %0d miscompares %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // ****************************************
  // watchdog well beyond the planned span
  // ****************************************
  initial begin
    #(3000 * 25);
    miscompares++;
    end_sim();
  end
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    repeat (5) @(posedge sys_clk);
    #1;
    `CHK(level_mv, BLACK_MV)
    `CHK(rate_err, 1'b0)
    @(posedge sys_clk) reset <= 1'b0;
    repeat (800) @(posedge sys_clk);
    #1;
    `CHK(rate_err, 1'b0)
    $display("test random stream done");
    @(posedge sys_clk) hurry <= 1'b1; // offers too close together
    repeat (12) @(posedge sys_clk);
    #1;
    `CHK(rate_err, 1'b1)
    $display("test rate refusal done");
    @(posedge sys_clk) begin hurry <= 1'b0; reset <= 1'b1; end
    repeat (2) @(posedge sys_clk);
    #1;
    `CHK(rate_err, 1'b0)
    `CHK(level_sel, 2'(VDAC_SEL_GREY))
    @(posedge sys_clk) reset <= 1'b0;
    repeat (200) @(posedge sys_clk);
    $display("test second reset done");
    end_sim();
  end
endmodule
`default_nettype wire
